//--- timer16_pkg.sv
/*
  Shared constants for the 16-bit timer/event counter core: register
  indices, field positions, reset values, mode and edge encodings.
  Assumes a 32-bit Avalon-MM slave with byte addresses; each register
  index sits at byte address index*4.
*/
package timer16_pkg;

  localparam int unsigned REG_DW = 16;
  localparam int unsigned ADDR_W = 18;

  // Register indices; byte address is index * 4
  localparam logic [15:0] IDX_COUNT  = 16'hFF12;
  localparam logic [15:0] IDX_CC1    = 16'hFF14;
  localparam logic [15:0] IDX_CC2    = 16'hFF16;
  localparam logic [15:0] IDX_MODE   = 16'hFF60;
  localparam logic [15:0] IDX_CCCTL  = 16'hFF62;
  localparam logic [15:0] IDX_PRESC  = 16'hFF64;
  localparam logic [15:0] IDX_OUTCTL = 16'hFF66;

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;

  // Mode control byte: bit0 overflow, bits 3..1 mode
  localparam int MODE_OVF_BIT = 0;
  localparam int MODE_LSB     = 1;
  localparam int MODE_W       = 3;
  // Capture/compare control byte
  localparam int CC_FIRST_MODE_BIT  = 0;
  localparam int CC_FIRST_SRC_BIT   = 1;
  localparam int CC_SECOND_MODE_BIT = 2;
  localparam int CCCTL_W            = 3;
  // Prescaler mode byte
  localparam int PRESC_CLK_LSB = 0;
  localparam int ES_FIRST_LSB  = 4;
  localparam int ES_SECOND_LSB = 6;
  localparam int PRESC_W       = 8;
  // Output control byte
  localparam int OUT_ENABLE_BIT  = 0;
  localparam int OUT_ONESHOT_BIT = 1;
  localparam int OUT_TRIGGER_BIT = 2;
  localparam int OUTCTL_W        = 2;

  localparam logic [1:0] BE_LOW_HALF = 2'b11;
  localparam logic [7:0] DIV_STEP    = 8'h01;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0] {
    OP_STOP      = 2'b00,
    OP_FREE      = 2'b01,
    OP_EDGE_CLR  = 2'b10,
    OP_MATCH_CLR = 2'b11
  } op_mode_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;

  function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                   input logic [15:0]       idx);
    return addr == {idx, 2'b00};
  endfunction

  // Count clock divider mask: fxp, /2, /16, /256
  function automatic logic [7:0] presc_mask(input logic [1:0] sel);
    logic [7:0] m;
    case (sel)
      2'b00:   m = 8'h00;
      2'b01:   m = 8'h01;
      2'b10:   m = 8'h0F;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction

endpackage

//--- edge_sense.sv
/*
  Edge detector for one timer input pin: two-flop synchroniser, then
  normal-phase and reverse-phase valid-edge decode.
  Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module edge_sense
  import timer16_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       pin_in,
  input  wire logic [1:0] sel,
  output logic            hit,
  output logic            hit_rev
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } edge_st_t;

  edge_st_t st_q;
  edge_st_t st_d;
  logic     rise;
  logic     fall;

  assign rise = st_q.s2 && !st_q.prev;
  assign fall = !st_q.s2 && st_q.prev;

  always_comb
  begin
    st_d      = st_q;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.prev = st_q.s2;
    case (sel)
      EDGE_FALL: hit = fall;
      EDGE_RISE: hit = rise;
      EDGE_BOTH: hit = rise || fall;
      default:   hit = 1'b0;
    endcase
    // Reverse phase: code 00 takes rising, 01 falling, 11 nothing
    case (sel)
      EDGE_FALL: hit_rev = rise;
      EDGE_RISE: hit_rev = fall;
      default:   hit_rev = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

endmodule

//--- capcomp_reg.sv
/*
  One capture/compare register: loads the count on a capture trigger,
  otherwise takes software writes.
  Assumes the caller qualifies cap_en and wr_en.
*/
`timescale 1ns/10ps
module capcomp_reg
  import timer16_pkg::*;
#(
  parameter int unsigned W = REG_DW
)
(
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         cap_en,
  input  wire logic [W-1:0] count,
  output logic      [W-1:0] value
);

  if (W < 1 || W > 32)
    $error("capcomp_reg width out of range");

  typedef struct packed {
    logic [W-1:0] value;
  } cc_st_t;

  cc_st_t st_q;
  cc_st_t st_d;

  assign value = st_q.value;

  always_comb
  begin
    st_d = st_q;
    if (cap_en)
      st_d.value = count;
    else if (wr_en)
      st_d.value = wr_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

  cap_load_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && cap_en |=> value == $past(count))
    else $error("capture did not load the count");

endmodule

//--- timer16_capture_compare_core.sv
/*
  16-bit timer/event counter core with two capture/compare registers,
  an Avalon-MM register slave with waitrequest, and the shared output pin.
  Assumes edge inputs are asynchronous pins and the bus master keeps
  its request steady until it samples waitrequest low.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
// How it works
// - count increments on each selected count tick
// - count read holds tick, returns value
// - count cleared on reset and stop mode
// - edge-clear mode clears on first input edge
// - match-clear mode clears on first match
// - one-shot trigger clears the count
// - control bit 0 picks first register mode
// - first register resets to zero
// - first compare match raises first interrupt
// - first input captures into first reversed
// - second input captures into first register
// - edge fields at prescaler bits 5:4, 7:6
// - zero compare matches on 0001 after wrap
// - lowered compare waits for wrap around
// - capture stays correct during register read
// - stop during capture gives undefined capture
// - control bit 2 picks second register mode
// - second register resets to zero
// - first register 16-bit writes, count read-only
// - second compare match raises second interrupt
// - nonzero upper two mode bits start, zero stops
`timescale 1ns/10ps
module timer16_capture_compare_core
  import timer16_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              edge_input_first,
  input  wire logic              shared_pin_in,
  output logic                   shared_pin_out,
  output logic                   shared_pin_oe,
  output logic                   first_match_irq,
  output logic                   second_match_irq
);

  typedef struct packed {
    logic [15:0]         count;
    logic                ovf;
    logic                fresh;
    logic [MODE_W-1:0]   mode;
    logic [CCCTL_W-1:0]  ccctl;
    logic [PRESC_W-1:0]  presc;
    logic [OUTCTL_W-1:0] outctl;
    logic [7:0]          div;
    bus_state_t          bstate;
    logic                waitreq;
    logic [15:0]         rdata;
    logic                irq1;
    logic                irq2;
    logic                tout;
  } core_st_t;

  localparam core_st_t ST_RESET = '{waitreq: 1'b1, bstate: BUS_IDLE,
                                    default: '0};

  core_st_t    st_q;
  core_st_t    st_d;
  op_mode_t    op;
  logic        run;
  logic        hold;
  logic        tick;
  logic [7:0]  mask;
  logic        wr_commit;
  logic        trig;
  logic        edge_clr;
  logic        first_hit;
  logic        first_rev;
  logic        second_hit;
  logic        cap1;
  logic        cap2;
  logic        cc1_wr;
  logic        cc2_wr;
  logic [15:0] cc1_val;
  logic [15:0] cc2_val;
  logic        eq1;
  logic        eq2;
  logic        match1;
  logic        match2;
  logic [15:0] rd_val;

  assign avs_readdata     = {16'h0000, st_q.rdata};
  assign avs_waitrequest  = st_q.waitreq;
  assign shared_pin_out   = st_q.tout;
  // pin driven only while output is enabled
  assign shared_pin_oe    = st_q.outctl[OUT_ENABLE_BIT];
  assign first_match_irq  = st_q.irq1;
  assign second_match_irq = st_q.irq2;

  edge_sense u_edge_first (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .pin_in  (edge_input_first),
    .sel     (st_q.presc[ES_FIRST_LSB +: 2]),
    .hit     (first_hit),
    .hit_rev (first_rev)
  );

  edge_sense u_edge_second (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .pin_in  (shared_pin_in),
    .sel     (st_q.presc[ES_SECOND_LSB +: 2]),
    .hit     (second_hit),
    .hit_rev ()
  );

  capcomp_reg #(.W(REG_DW)) u_cc1 (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .wr_en   (cc1_wr),
    .wr_data (avs_writedata[15:0]),
    .cap_en  (cap1),
    .count   (st_q.count),
    .value   (cc1_val)
  );

  capcomp_reg #(.W(REG_DW)) u_cc2 (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .wr_en   (cc2_wr),
    .wr_data (avs_writedata[15:0]),
    .cap_en  (cap2),
    .count   (st_q.count),
    .value   (cc2_val)
  );

  // a nonzero value in the upper two mode bits runs the counter
  assign op   = op_mode_t'(st_q.mode[MODE_W-1 -: 2]);
  assign run  = op != OP_STOP;
  // hold off the count tick during a count read
  assign hold = run && avs_read && st_q.bstate == BUS_IDLE
                && addr_is(avs_address, IDX_COUNT);
  assign mask = presc_mask(st_q.presc[PRESC_CLK_LSB +: 2]);
  assign tick = run && !hold && ((st_q.div & mask) == mask);

  assign wr_commit = avs_write && st_q.bstate == BUS_DONE;
  assign trig      = wr_commit && addr_is(avs_address, IDX_OUTCTL)
                     && st_q.outctl[OUT_ONESHOT_BIT]
                     && avs_writedata[OUT_TRIGGER_BIT];
  assign edge_clr  = op == OP_EDGE_CLR && first_hit;

  // first register only takes 16-bit writes
  assign cc1_wr = wr_commit && addr_is(avs_address, IDX_CC1)
                  && avs_byteenable[1:0] == BE_LOW_HALF;
  assign cc2_wr = wr_commit && addr_is(avs_address, IDX_CC2)
                  && avs_byteenable[1:0] == BE_LOW_HALF;

  // bit 0 selects capture; trigger source
  assign cap1 = st_q.ccctl[CC_FIRST_MODE_BIT]
                && (st_q.ccctl[CC_FIRST_SRC_BIT] ? first_rev : second_hit);
  // bit 2 selects capture on first input edge
  // a capture during stop takes whatever count is present
  assign cap2 = st_q.ccctl[CC_SECOND_MODE_BIT] && first_hit;

  assign eq1 = st_q.count == cc1_val;
  assign eq2 = st_q.count == cc2_val;

  // zero compare is skipped until the count wraps
  assign match1 = tick && !st_q.ccctl[CC_FIRST_MODE_BIT] && eq1
                  && !(st_q.fresh && cc1_val == CNT_RESET);
  assign match2 = tick && !st_q.ccctl[CC_SECOND_MODE_BIT] && eq2
                  && !(st_q.fresh && cc2_val == CNT_RESET);

  always_comb
  begin
    if (addr_is(avs_address, IDX_COUNT))
      rd_val = st_q.count;
    else if (addr_is(avs_address, IDX_CC1))
      rd_val = cc1_val;
    else if (addr_is(avs_address, IDX_CC2))
      rd_val = cc2_val;
    else if (addr_is(avs_address, IDX_MODE))
      rd_val = {12'h000, st_q.mode, st_q.ovf};
    else if (addr_is(avs_address, IDX_CCCTL))
      rd_val = {13'h0000, st_q.ccctl};
    else if (addr_is(avs_address, IDX_PRESC))
      rd_val = {8'h00, st_q.presc};
    else if (addr_is(avs_address, IDX_OUTCTL))
      rd_val = {14'h0000, st_q.outctl};
    else
      rd_val = 16'h0000;
  end

  always_comb
  begin
    st_d      = st_q;
    st_d.irq1 = match1;
    st_d.irq2 = match2;

    case (st_q.bstate)
      BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          st_d.bstate  = BUS_DONE;
          st_d.waitreq = 1'b0;
          // read data latched apart from capture storage
          if (avs_read)
            st_d.rdata = rd_val;
        end
      end
      BUS_DONE:
      begin
        st_d.bstate  = BUS_IDLE;
        st_d.waitreq = 1'b1;
        if (avs_write && avs_byteenable[0])
        begin
          if (addr_is(avs_address, IDX_MODE))
          begin
            st_d.mode = avs_writedata[MODE_LSB +: MODE_W];
            if (!avs_writedata[MODE_OVF_BIT])
              st_d.ovf = 1'b0;
          end
          if (addr_is(avs_address, IDX_CCCTL))
            st_d.ccctl = avs_writedata[CCCTL_W-1:0];
          if (addr_is(avs_address, IDX_PRESC))
            st_d.presc = avs_writedata[PRESC_W-1:0];
          if (addr_is(avs_address, IDX_OUTCTL))
            st_d.outctl = avs_writedata[OUTCTL_W-1:0];
        end
      end
      default:
      begin
        st_d.bstate  = BUS_IDLE;
        st_d.waitreq = 1'b1;
      end
    endcase

    if (run && !hold)
      st_d.div = st_q.div + DIV_STEP;
    else if (!run)
      st_d.div = '0;

    if (!run)
    begin
      st_d.count = CNT_RESET;
      st_d.fresh = 1'b1;
    end
    else if (trig || edge_clr)
    begin
      // one-shot trigger or valid edge clears
      st_d.count = CNT_RESET;
      st_d.fresh = 1'b1;
    end
    else if (tick)
    begin
      st_d.fresh = 1'b0;
      if (op == OP_MATCH_CLR && eq1)
        st_d.count = CNT_RESET;
      else
        st_d.count = st_q.count + CNT_ONE;
      // Overflow set wins over a software clear
      if (st_q.count == CNT_MAX)
        st_d.ovf = 1'b1;
    end

    if ((match1 || match2) && st_q.outctl[OUT_ENABLE_BIT])
      st_d.tout = !st_q.tout;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      st_q <= ST_RESET;
    else if (ce)
      st_q <= st_d;
  end

  count_inc_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && !trig && !edge_clr && !(op == OP_MATCH_CLR && eq1)
    |=> st_q.count == 16'($past(st_q.count) + CNT_ONE))
    else $error("count did not step by one");

  read_hold_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && hold && !trig && !edge_clr |=> st_q.count == $past(st_q.count))
    else $error("count moved during a count read");

  read_value_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && hold |=> !avs_waitrequest && avs_readdata[15:0] == $past(st_q.count))
    else $error("count read returned a wrong value");

  stop_clear_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && !run |=> st_q.count == CNT_RESET)
    else $error("stopped counter not cleared");

  edge_clear_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && run && edge_clr |=> st_q.count == CNT_RESET)
    else $error("valid edge did not clear count");

  match_clear_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && op == OP_MATCH_CLR && eq1 && !trig
    |=> st_q.count == CNT_RESET)
    else $error("match did not clear count");

  oneshot_clr_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && run && trig |=> st_q.count == CNT_RESET)
    else $error("one-shot trigger did not clear count");

  first_irq_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && !st_q.ccctl[CC_FIRST_MODE_BIT] && eq1
    && cc1_val != CNT_RESET |=> first_match_irq)
    else $error("first match interrupt missing");

  wrap_match_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && !st_q.fresh && st_q.count == CNT_RESET
    && cc1_val == CNT_RESET && !st_q.ccctl[CC_FIRST_MODE_BIT]
    |=> first_match_irq && st_q.count == CNT_ONE)
    else $error("zero compare missed after wrap");

  second_irq_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && !st_q.ccctl[CC_SECOND_MODE_BIT] && eq2
    && cc2_val != CNT_RESET |=> second_match_irq)
    else $error("second match interrupt missing");

  narrow_write_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && wr_commit && addr_is(avs_address, IDX_CC1) && !cap1
    && avs_byteenable[1:0] != BE_LOW_HALF |=> cc1_val == $past(cc1_val))
    else $error("narrow write changed first register");

endmodule

//--- edge_source.sv
/*
  Model of the pulse sources wired to the two timer input pins.
  Assumes the bench asks for levels; each level is held at least three clocks.
*/
`timescale 1ns/10ps
module edge_source
(
  input  wire logic sys_clk,
  input  wire logic want_first,
  input  wire logic want_second,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      edge_input_first,
  output logic      shared_pin_in
);
  logic       second_drv = 1'b0;
  logic [1:0] age_first  = 2'd0;
  logic [1:0] age_second = 2'd0;

  initial edge_input_first = 1'b0;

  // Minimum level width of three clocks on edge_input_first and second_drv
  always @(posedge sys_clk)
  begin
    if (age_first != 2'd3)
      age_first <= age_first + 2'd1;
    if (age_second != 2'd3)
      age_second <= age_second + 2'd1;
    if (want_first != edge_input_first && age_first >= 2'd2)
    begin
      edge_input_first <= want_first;
      age_first        <= 2'd0;
    end
    if (want_second != second_drv && age_second >= 2'd2)
    begin
      second_drv <= want_second;
      age_second <= 2'd0;
    end
  end

  assign shared_pin_in = pin_oe ? pin_out : second_drv;
endmodule

//--- timer16_capture_compare_core_bench.sv
/*
  Self-checking bench for the timer core: bus tasks, capture edge
  table, match periods, clears, zero-compare wrap.
  Assumes edge_source models the input pins.
*/
`timescale 1ns/10ps
module timer16_capture_compare_core_bench;
  import timer16_pkg::*;
  logic              sys_clk        = 1'b0;
  logic              resetn         = 1'b0;
  logic [ADDR_W-1:0] avs_address    = '0;
  logic              avs_read       = 1'b0;
  logic              avs_write      = 1'b0;
  logic [31:0]       avs_writedata  = 32'h0;
  logic [3:0]        avs_byteenable = 4'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              edge_input_first;
  logic              shared_pin_in;
  logic              shared_pin_out;
  logic              shared_pin_oe;
  logic              first_match_irq;
  logic              second_match_irq;
  logic              want_first     = 1'b0;
  logic              want_second    = 1'b0;
  logic [31:0]       rd;
  logic [15:0]       v;
  logic [1:0]        codes [3]      = '{2'b00, 2'b01, 2'b11};
  logic [15:0]       zidx [5];
  int                bad_count      = 0;
  int                n_checks       = 0;
  int                c;
  int                n;
  int                m;
  int                p;
  logic              last_out;

  always #20 sys_clk = ~sys_clk;

  timer16_capture_compare_core u_timer16_capture_compare_core (
    .sys_clk(sys_clk), .resetn(resetn), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .edge_input_first(edge_input_first), .shared_pin_in(shared_pin_in),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
    .first_match_irq(first_match_irq), .second_match_irq(second_match_irq));

  edge_source u_edge_source (
    .sys_clk(sys_clk), .want_first(want_first), .want_second(want_second),
    .pin_out(shared_pin_out), .pin_oe(shared_pin_oe),
    .edge_input_first(edge_input_first), .shared_pin_in(shared_pin_in));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; called just after a rising edge
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, input logic [3:0] be);
    int k;
    avs_address    <= {idx, 2'b00};
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50)
    begin
      bad_count++;
      tally_and_finish;
    end
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                    input logic [3:0] be);
    bus(1'b1, idx, d, be);
  endtask

  task automatic rdr(input logic [15:0] idx);
    bus(1'b0, idx, 32'h0, 4'hF);
  endtask

  task automatic wait_irq(input logic second, output int k);
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while ((second ? second_match_irq : first_match_irq) !== 1'b1
           && k < 2000);
    if (k >= 2000)
    begin
      bad_count++;
      tally_and_finish;
    end
  endtask

  function automatic logic norm_cap(input logic [1:0] cd, input logic r);
    return cd == 2'b11 || (cd == 2'b01 && r) || (cd == 2'b00 && !r);
  endfunction

  function automatic logic rev_cap(input logic [1:0] cd, input logic r);
    return (cd == 2'b01 && !r) || (cd == 2'b00 && r);
  endfunction

  initial
  begin
    void'($urandom(79));
    zidx = '{IDX_COUNT, IDX_CC1, IDX_CC2, IDX_MODE, 16'hFF70};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    foreach (zidx[i])
    begin
      rdr(zidx[i]);
      check(rd, 32'h0);
    end
    v = 16'($urandom_range(16'hFFFE, 1));
    wr(IDX_CC1, {16'h0, v}, 4'hF);
    wr(IDX_CC1, {16'h0, ~v}, 4'h1);
    rdr(IDX_CC1);
    check(rd, {16'h0, v});
    wr(IDX_MODE, 32'h04, 4'h1);
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 3; k++)
        for (int r = 1; r >= 0; r--)
        begin
          wr(IDX_CCCTL, {29'h0, 1'b1, s[0], 1'b1}, 4'h1);
          wr(IDX_PRESC, {24'h0, codes[k], codes[k], 4'h0}, 4'h1);
          wr(IDX_CC1, 32'h0, 4'h3);
          wr(IDX_CC2, 32'h0, 4'h3);
          if (s == 1)
            want_first <= r[0];
          else
            want_second <= r[0];
          repeat (12) @(posedge sys_clk);
          rdr(IDX_CC1);
          check(32'(rd != 0), 32'(s ? rev_cap(codes[k], r[0])
                                    : norm_cap(codes[k], r[0])));
          rdr(IDX_CC2);
          check(32'(rd != 0), 32'(s ? norm_cap(codes[k], r[0])
                                    : 1'b0));
        end
    wr(IDX_COUNT, 32'h0, 4'hF);
    rdr(IDX_COUNT);
    check(32'(rd != 0), 32'h1);
    check(32'(rd > 16), 32'h1);
    wr(IDX_MODE, 32'h0, 4'h1);
    rdr(IDX_COUNT);
    check(rd, 32'h0);
    n = $urandom_range(40, 8);
    m = $urandom_range(n - 1, 1);
    wr(IDX_CCCTL, 32'h0, 4'h1);
    wr(IDX_PRESC, 32'h0, 4'h1);
    wr(IDX_CC1, 32'(n), 4'h3);
    wr(IDX_CC2, 32'(m), 4'h3);
    wr(IDX_MODE, 32'h0C, 4'h1);
    wait_irq(1'b0, c);
    wait_irq(1'b0, c);
    check(32'(c), 32'(n + 1));
    wait_irq(1'b1, c);
    wait_irq(1'b1, c);
    check(32'(c), 32'(n + 1));
    wr(IDX_PRESC, 32'h02, 4'h1);
    wait_irq(1'b0, c);
    wait_irq(1'b0, c);
    check(32'(c), 32'((n + 1) * 16));
    wr(IDX_MODE, 32'h0, 4'h1);
    wr(IDX_PRESC, 32'h10, 4'h1);
    wr(IDX_MODE, 32'h08, 4'h1);
    repeat (100) @(posedge sys_clk);
    want_first <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdr(IDX_COUNT);
    check(32'(rd < 16), 32'h1);
    repeat (100) @(posedge sys_clk);
    wr(IDX_OUTCTL, 32'h02, 4'h1);
    wr(IDX_OUTCTL, 32'h06, 4'h1);
    rdr(IDX_COUNT);
    check(32'(rd < 16), 32'h1);
    wr(IDX_OUTCTL, 32'h01, 4'h1);
    check(32'(shared_pin_oe), 32'h1);
    wr(IDX_MODE, 32'h0, 4'h1);
    wr(IDX_CC1, 32'h0, 4'h3);
    wr(IDX_MODE, 32'h04, 4'h1);
    m = 0;
    p = 0;
    last_out = shared_pin_out;
    repeat (65600)
    begin
      @(posedge sys_clk);
      if (first_match_irq === 1'b1)
        m++;
      if (shared_pin_out !== last_out)
        p++;
      last_out = shared_pin_out;
    end
    check(32'(m), 32'h1);
    check(32'(p), 32'h3);
    rdr(IDX_MODE);
    check(rd, 32'h05);
    tally_and_finish;
  end
endmodule
